// ### inc/rid_pkg.sv
// Purpose: shared constants and types of the instruction decoder
// Assumes: 14-bit instruction words, 8-bit data
// Notes:   register byte offsets are AXI4-Lite byte addresses
package rid_pkg;
  localparam int          OSC_PERIOD_NS  = 10;
  localparam int          INSTR_CYCLE_NS = 4 * OSC_PERIOD_NS;
  localparam logic [1:0]  INSTR_DIV_LAST = 2'(INSTR_CYCLE_NS / OSC_PERIOD_NS - 1);
  // Register map
  localparam logic [7:0]  OFS_INSTR  = 8'h00;
  localparam logic [7:0]  OFS_WREG   = 8'h04;
  localparam logic [7:0]  OFS_STATUS = 8'h08;
  localparam logic [7:0]  OFS_PC     = 8'h0C;
  // Status field positions
  localparam int          ST_C_BIT    = 0;
  localparam int          ST_DC_BIT   = 1;
  localparam int          ST_Z_BIT    = 2;
  localparam int          ST_PD_BIT   = 3;
  localparam int          ST_TO_BIT   = 4;
  localparam int          ST_SB_BIT   = 7;
  localparam int          ST_BUSY_BIT = 8;
  localparam logic        RST_TO = 1'b1;
  localparam logic        RST_PD = 1'b1;
  // File addresses with side effects
  localparam logic [6:0]  TIMER0_ADDR = 7'h01;
  localparam logic [6:0]  PORT_ADDR   = 7'h05;
  // Fixed control words
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_INTERRUPT_RETURN = 14'h0009;
  localparam logic [13:0] W_SLEEP  = 14'h0063;
  localparam logic [13:0] W_CLEAR_WATCHDOG = 14'h0064;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_SECOND} rid_state_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
  } rid_file_req_t;
endpackage : rid_pkg

// ### logic/rid_core.sv
// Purpose: decode and execute one 14-bit instruction word per instruction cycle
// Assumes: software writes each word at the current program counter; file storage is outside
// Notes:   writes to INSTR while busy are refused with SLVERR
// Functional notes
// - Top bits 00 are byte file ops; code 0100 ORs working register with file.
// - Byte codes 0110 XOR and 0101 AND; logic ops update only zero.
// - Codes 1011 decrement, 1111 increment, skip next when zero, no flags.
// - Codes 1101 and 1100 rotate left/right through carry, only carry changes.
// - Top bits 01 are bit ops; operation 10 skips when bit clear.
// - Bit operation 11 skips when bit set, no flags.
// - Top bits 11 literal ops; 1000 OR, 1001 AND, zero flag only.
// - Literal 1010 XOR updates zero; 00xx loads literal without flags.
// - 110x literal minus working, 111x add; update carry, digit carry, zero.
// - 01xx loads literal and returns from subroutine in two cycles.
// - Standby and watchdog-clear words take one cycle, set timeout; standby clears power-down, watchdog-clear sets it.
// - Port reads for rewrite use synchronised pin levels, not the latch.
// - Writing timer0 count clears prescaler when it is assigned to timer0.
// - PC change or true test takes two cycles, second is a no-op.
// - Destination bit zero writes working register, one writes the file.
// - One instruction cycle is four clock periods.
`timescale 1ns/100ps
module rid_core (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output rid_pkg::rid_file_req_t      fileReq,
  input  wire logic [7:0]             fileRdData,
  input  wire logic [7:0]             pinLevels,
  input  wire logic                   prescalerToTimer0,
  output logic                        prescalerClear,
  output logic                        watchdogClear,
  output logic                        standby
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0]          divCnt;
  logic                tick;
  rid_pkg::rid_state_t state;
  logic [13:0]         instr;
  logic [7:0]          wreg;
  logic                cFlag, dcFlag, zFlag, toFlag, pdFlag;
  logic [12:0]         pc;
  logic [12:0]         stack [8];
  logic [2:0]          sp;
  logic [7:0]          pinMeta, pinSync;
  logic                commit;
  // Execute results
  logic [7:0]  res, opnd;
  logic [12:0] next_pc;
  logic        wrW, wrF, updZ, updC, updDc, next_c, next_dc;
  logic        twoCycle, skip, push, pop, doSleep, doWdt;
  // Bus
  logic        awHeld, wHeld, doWrite, wrInstr, wrWreg;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  // File request fields, packed into the port struct in one place
  logic [7:0]  reqWrData;
  logic        reqWrEn;

  function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction : addc

  ////////////////////////////////////////////////////////////////////////
  // four-clock cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) divCnt <= 2'h0;
    else       divCnt <= tick ? 2'h0 : divCnt + 2'h1;
  end
  assign tick   = (divCnt == rid_pkg::INSTR_DIV_LAST);
  assign commit = tick && (state == rid_pkg::ST_READY);

  // Pins cross in from outside the clock domain
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
    end else begin
      pinMeta <= pinLevels;
      pinSync <= pinMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign fileReq = '{addr: instr[6:0], wrData: reqWrData, wrEn: reqWrEn};
  assign opnd = (instr[6:0] == rid_pkg::PORT_ADDR) ? pinSync : fileRdData;

  always_comb begin
    res = 8'h00; wrW = 1'b0; wrF = 1'b0; updZ = 1'b0; updC = 1'b0; updDc = 1'b0;
    next_c = cFlag; next_dc = dcFlag; skip = 1'b0; push = 1'b0; pop = 1'b0;
    doSleep = 1'b0; doWdt = 1'b0; next_pc = pc + 13'h0001; twoCycle = 1'b0;
    unique case (instr[13:12])
      2'b00: begin
        unique case (instr[11:8])
          4'h0: begin
            res = wreg;
            wrF = instr[7];
            if (instr == rid_pkg::W_RETURN || instr == rid_pkg::W_INTERRUPT_RETURN) begin
              pop = 1'b1;
              next_pc = stack[sp - 3'h1];
            end
            doSleep = (instr == rid_pkg::W_SLEEP);
            doWdt   = (instr == rid_pkg::W_CLEAR_WATCHDOG);
          end
          4'h1: begin res = 8'h00; updZ = 1'b1; end
          4'h2: begin {next_c, next_dc, res} = addc(opnd, ~wreg, 1'b1); updC = 1'b1; updDc = 1'b1; updZ = 1'b1; end
          4'h7: begin {next_c, next_dc, res} = addc(opnd, wreg, 1'b0); updC = 1'b1; updDc = 1'b1; updZ = 1'b1; end
          4'h3: begin res = opnd - 8'h01; updZ = 1'b1; end
          4'h4: begin res = wreg | opnd; updZ = 1'b1; end
          4'h5: begin res = wreg & opnd; updZ = 1'b1; end
          4'h6: begin res = wreg ^ opnd; updZ = 1'b1; end
          4'h8: begin res = opnd; updZ = 1'b1; end
          4'h9: begin res = ~opnd; updZ = 1'b1; end
          4'hA: begin res = opnd + 8'h01; updZ = 1'b1; end
          4'hB: begin res = opnd - 8'h01; skip = (res == 8'h00); end
          4'hF: begin res = opnd + 8'h01; skip = (res == 8'h00); end
          4'hC: begin res = {cFlag, opnd[7:1]}; next_c = opnd[0]; updC = 1'b1; end
          4'hD: begin res = {opnd[6:0], cFlag}; next_c = opnd[7]; updC = 1'b1; end
          4'hE: res = {opnd[3:0], opnd[7:4]};
        endcase
        if (instr[11:8] != 4'h0) begin
          wrW = !instr[7];
          wrF = instr[7];
        end
      end
      2'b01: begin
        res = opnd;
        unique case (instr[11:10])
          2'b00: begin res[instr[9:7]] = 1'b0; wrF = 1'b1; end
          2'b01: begin res[instr[9:7]] = 1'b1; wrF = 1'b1; end
          2'b10: skip = !opnd[instr[9:7]];
          2'b11: skip = opnd[instr[9:7]];
        endcase
      end
      2'b10: begin
        next_pc = {2'b00, instr[10:0]};
        push = !instr[11];
      end
      2'b11: begin
        wrW = 1'b1;
        unique casez (instr[11:8])
          4'b00??: res = instr[7:0];
          4'b01??: begin res = instr[7:0]; pop = 1'b1; next_pc = stack[sp - 3'h1]; end
          4'b1000: begin res = wreg | instr[7:0]; updZ = 1'b1; end
          4'b1001: begin res = wreg & instr[7:0]; updZ = 1'b1; end
          4'b1010: begin res = wreg ^ instr[7:0]; updZ = 1'b1; end
          4'b1011: wrW = 1'b0;
          4'b110?: begin {next_c, next_dc, res} = addc(instr[7:0], ~wreg, 1'b1); updC = 1'b1; updDc = 1'b1; updZ = 1'b1; end
          4'b111?: begin {next_c, next_dc, res} = addc(instr[7:0], wreg, 1'b0); updC = 1'b1; updDc = 1'b1; updZ = 1'b1; end
        endcase
      end
    endcase
    if (skip) next_pc = pc + 13'h0002;
    twoCycle = skip || push || pop || (instr[13:12] == 2'b10);
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= rid_pkg::ST_IDLE;
      instr <= 14'h0000;
    end else begin
      unique case (state)
        rid_pkg::ST_IDLE: if (wrInstr) begin
          instr <= wData[13:0];
          state <= rid_pkg::ST_READY;
        end
        rid_pkg::ST_READY: if (tick) state <= twoCycle ? rid_pkg::ST_SECOND : rid_pkg::ST_IDLE;
        rid_pkg::ST_SECOND: if (tick) state <= rid_pkg::ST_IDLE;
      endcase
    end
  end

  // Working register and flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wreg <= 8'h00; cFlag <= 1'b0; dcFlag <= 1'b0; zFlag <= 1'b0;
      toFlag <= rid_pkg::RST_TO; pdFlag <= rid_pkg::RST_PD;
    end else if (commit) begin
      if (wrW) wreg <= res;
      if (updC) cFlag <= next_c;
      if (updDc) dcFlag <= next_dc;
      if (updZ) zFlag <= (res == 8'h00);
      if (doSleep) begin toFlag <= 1'b1; pdFlag <= 1'b0; end
      if (doWdt) begin toFlag <= 1'b1; pdFlag <= 1'b1; end
    end else if (wrWreg && wStrb[0]) begin
      wreg <= wData[7:0];
    end
  end

  // Program counter and 8-level stack, wraps on overflow
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc <= 13'h0000;
      sp <= 3'h0;
      for (int i = 0; i < 8; i++) stack[i] <= 13'h0000;
    end else if (commit) begin
      pc <= next_pc;
      if (push) begin
        stack[sp] <= pc + 13'h0001;
        sp <= sp + 3'h1;
      end else if (pop) begin
        sp <= sp - 3'h1;
      end
    end
  end

  // File write and side-effect strobes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reqWrData <= 8'h00; reqWrEn <= 1'b0;
      prescalerClear <= 1'b0; watchdogClear <= 1'b0; standby <= 1'b0;
    end else begin
      reqWrEn        <= commit && wrF;
      watchdogClear  <= commit && doWdt;
      prescalerClear <= commit && wrF && (instr[6:0] == rid_pkg::TIMER0_ADDR) && prescalerToTimer0;
      if (commit && wrF) reqWrData <= res;
      // A new instruction word wakes the core
      if (commit && doSleep) standby <= 1'b1;
      else if (wrInstr) standby <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wrInstr = doWrite && (awAddr == rid_pkg::OFS_INSTR) && (state == rid_pkg::ST_IDLE);
  assign wrWreg  = doWrite && (awAddr == rid_pkg::OFS_WREG) && (state == rid_pkg::ST_IDLE);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0; wHeld <= 1'b0; awAddr <= 8'h00; wData <= 32'h0000_0000; wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= rid_pkg::RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin awHeld <= 1'b1; awAddr <= s_axi_awaddr[7:0]; end
      if (s_axi_wvalid && s_axi_wready) begin wHeld <= 1'b1; wData <= s_axi_wdata; wStrb <= s_axi_wstrb; end
      if (doWrite) begin
        awHeld <= 1'b0; wHeld <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrInstr || wrWreg) ? rid_pkg::RESP_OK : rid_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= rid_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rid_pkg::RESP_OK;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        rid_pkg::OFS_INSTR: s_axi_rdata[13:0] <= instr;
        rid_pkg::OFS_WREG:  s_axi_rdata[7:0]  <= wreg;
        rid_pkg::OFS_STATUS: begin
          s_axi_rdata[rid_pkg::ST_C_BIT]    <= cFlag;
          s_axi_rdata[rid_pkg::ST_DC_BIT]   <= dcFlag;
          s_axi_rdata[rid_pkg::ST_Z_BIT]    <= zFlag;
          s_axi_rdata[rid_pkg::ST_PD_BIT]   <= pdFlag;
          s_axi_rdata[rid_pkg::ST_TO_BIT]   <= toFlag;
          s_axi_rdata[rid_pkg::ST_SB_BIT]   <= standby;
          s_axi_rdata[rid_pkg::ST_BUSY_BIT] <= (state != rid_pkg::ST_IDLE);
        end
        rid_pkg::OFS_PC: s_axi_rdata[12:0] <= pc;
        default: s_axi_rresp <= rid_pkg::RESP_ERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_TICK_PERIOD: assert property (tick |=> !tick [*3] ##1 tick) else $error("cycle not four clocks");
  AST_TWO_CYCLE: assert property (commit && twoCycle |=> state == rid_pkg::ST_SECOND [*4] ##1 state == rid_pkg::ST_IDLE)
    else $error("two-cycle op wrong length");
  AST_LOGIC_Z: assert property (commit && instr[13:12] == 2'b00 && instr[11:8] inside {4'h4, 4'h5, 4'h6}
    |=> cFlag == $past(cFlag) && dcFlag == $past(dcFlag) && zFlag == ($past(res) == 8'h00))
    else $error("logic op flag update wrong");
  AST_RLF_CARRY: assert property (commit && instr[13:8] == 6'h0D |=> cFlag == $past(opnd[7]) && zFlag == $past(zFlag))
    else $error("rotate carry wrong");
  AST_DEST_FILE: assert property (commit && instr[13:12] == 2'b00 && instr[11:8] != 4'h0 && instr[7]
    |=> fileReq.wrEn && fileReq.wrData == $past(res) && wreg == $past(wreg)) else $error("file destination wrong");
  AST_PORT_PINS: assert property (commit && instr[13:7] == 7'h13 && instr[6:0] == rid_pkg::PORT_ADDR
    |=> fileReq.wrData == ~$past(pinSync)) else $error("port rewrite not from pins");
  AST_PRESCALER: assert property (commit && wrF && instr[6:0] == rid_pkg::TIMER0_ADDR && prescalerToTimer0
    |=> prescalerClear) else $error("prescaler not cleared");
  AST_SKIP_PC: assert property (commit && skip |=> pc == $past(pc) + 13'h0002) else $error("skip pc wrong");
  AST_SLEEP: assert property (commit && doSleep |=> standby && !pdFlag && toFlag && state == rid_pkg::ST_IDLE)
    else $error("standby entry wrong");
  AST_RETURN_WITH_LITERAL: assert property (commit && instr[13:10] == 4'hD |=> wreg == $past(instr[7:0]) && pc == $past(next_pc))
    else $error("return with literal wrong");
  AST_JUMP: assert property (commit && instr[13:11] == 3'b101 |=> pc == {2'b00, $past(instr[10:0])})
    else $error("jump target wrong");

  COV_SKIP:  cover property (commit && skip);
  COV_CALL:  cover property (commit && push);
  COV_SLEEP: cover property (commit && doSleep);
  COV_PORT:  cover property (commit && wrF && instr[6:0] == rid_pkg::PORT_ADDR);
endmodule : rid_core

// ### dv/test_risc14_instruction_decoder.sv
// Purpose: self-checking bench for the instruction decoder core
// Assumes: file storage is a bench array with combinational read
// Notes:   data and flag expectations come from the bench ALU model; PC expectations build on PC values read from the core
`timescale 1ns/100ps
module test_risc14_instruction_decoder;
  logic                   clock, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic                   arready, rvalid, presTo0, presClr, wdClr, standby;
  logic [31:0]            awaddr, wdata, araddr, rdata, seed, v;
  logic [1:0]             bresp, rresp, r;
  logic [7:0]             pins, wModel, lastWr, k;
  logic [2:0]             fModel;
  logic [7:0]             mem [128];
  int                     fails, nTests, nPres, nWdog;
  rid_pkg::rid_file_req_t fileReq;
  localparam logic [3:0] LIT_OPS [9] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
  localparam logic [3:0] BYTE_OPS [7] = '{4'h4, 4'h5, 4'h6, 4'h2, 4'h7, 4'hD, 4'hC};
  localparam int         BYTE_KIND [7] = '{1, 2, 3, 4, 5, 6, 7};

  rid_core DUT (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fileReq(fileReq),
    .fileRdData(mem[fileReq.addr]), .pinLevels(pins), .prescalerToTimer0(presTo0),
    .prescalerClear(presClr), .watchdogClear(wdClr), .standby(standby));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // File storage and pulse counters; pulses stand one cycle only
  always @(posedge clock) begin
    if (fileReq.wrEn) begin
      mem[fileReq.addr] <= fileReq.wrData;
      lastWr <= fileReq.wrData;
    end
    if (presClr) nPres <= nPres + 1;
    if (wdClr) nWdog <= nWdog + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Returns {zero, digit carry, carry, result}
  function automatic logic [10:0] alu(input int kind, input logic [7:0] a, input logic [7:0] w,
                                      input logic [2:0] f);
    logic [8:0] s;
    logic [7:0] q;
    logic [2:0] n;
    n = f;
    case (kind)
      1: q = w | a;
      2: q = w & a;
      3: q = w ^ a;
      4: begin
        q = a - w;
        n[0] = a >= w;
        n[1] = a[3:0] >= w[3:0];
      end
      5: begin
        s = a + w;
        q = s[7:0];
        n[0] = s[8];
        n[1] = (a[3:0] + w[3:0]) > 5'd15;
      end
      6: begin
        q = {a[6:0], f[0]};
        n[0] = a[7];
      end
      7: begin
        q = {f[0], a[7:1]};
        n[0] = a[0];
      end
      default: q = a;
    endcase
    if (kind >= 1 && kind <= 5) n[2] = (q == 8'h00);
    return {n, q};
  endfunction : alu

  function automatic int litKind(input logic [3:0] c);
    case (c)
      4'h8: return 1;
      4'h9: return 2;
      4'hA: return 3;
      4'hC, 4'hD: return 4;
      4'hE, 4'hF: return 5;
      default: return 0;
    endcase
  endfunction : litKind

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int t;
    logic gotA, gotW, gotB;
    @(posedge clock);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    gotB = 1'b0;
    while (!gotB && t < 50) begin
      @(posedge clock);
      gotA = awvalid && awready;
      gotW = wvalid && wready;
      gotB = bvalid;
      resp = bresp;
      if (gotA) awvalid <= 1'b0;
      if (gotW) wvalid <= 1'b0;
      if (gotB) bready <= 1'b0;
      t++;
    end
    if (!gotB) fails++;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int t;
    logic gotA, gotR;
    @(posedge clock);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    gotR = 1'b0;
    while (!gotR && t < 50) begin
      @(posedge clock);
      gotA = arvalid && arready;
      gotR = rvalid;
      d = rdata;
      resp = rresp;
      if (gotA) arvalid <= 1'b0;
      if (gotR) rready <= 1'b0;
      t++;
    end
    if (!gotR) fails++;
  endtask : axiRead

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] resp;
    axiRead(a, d, resp);
    check(resp, rid_pkg::RESP_OK);
  endtask : rd

  task automatic waitIdle();
    logic [31:0] s;
    int t;
    s = 32'h0000_0100;
    t = 0;
    while (s[rid_pkg::ST_BUSY_BIT] && t < 20) begin
      rd(rid_pkg::OFS_STATUS, s);
      t++;
    end
    if (s[rid_pkg::ST_BUSY_BIT]) fails++;
  endtask : waitIdle

  task automatic exec(input logic [13:0] word);
    logic [1:0] resp;
    axiWrite(rid_pkg::OFS_INSTR, {18'h0_0000, word}, resp);
    check(resp, rid_pkg::RESP_OK);
    waitIdle();
  endtask : exec

  task automatic setW(input logic [7:0] w);
    logic [1:0] resp;
    wModel = w;
    axiWrite(rid_pkg::OFS_WREG, {24'h00_0000, w}, resp);
  endtask : setW

  task automatic checkState();
    logic [31:0] s;
    rd(rid_pkg::OFS_WREG, s);
    check(s[7:0], wModel);
    rd(rid_pkg::OFS_STATUS, s);
    check(s[2:0], fModel);
  endtask : checkState

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    end_sim();
  end

  initial begin
    logic [31:0] p0, p1, x;
    logic [13:0] word;
    logic [6:0]  a;
    logic        sk;
    {nrst, awvalid, wvalid, bready, arvalid, rready, presTo0} = '0;
    {awaddr, wdata, araddr, pins, lastWr, fModel} = '0;
    {fails, nTests, nPres, nWdog} = '0;
    seed = 32'h0000_A241;
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd(rid_pkg::OFS_STATUS, v);
    check(v[4:3], 2'b11);
    $display("reset test done");
    // Carry, digit carry and zero all at once, then random literals
    setW(8'h01);
    for (int i = -1; i < 18; i++) begin
      word = (i < 0) ? 14'h3EFF : {2'b11, LIT_OPS[i % 9], 8'(rnd())};
      {fModel, wModel} = alu(litKind(word[11:8]), word[7:0], wModel, fModel);
      exec(word);
      checkState();
    end
    $display("literal test done");
    for (int i = 0; i < 14; i++) begin
      x = rnd();
      a = {2'b01, x[4:0]};
      mem[a] <= x[15:8];
      setW(x[23:16]);
      word = {2'b00, BYTE_OPS[i % 7], i >= 7, a};
      {fModel, p0[7:0]} = alu(BYTE_KIND[i % 7], x[15:8], wModel, fModel);
      if (i < 7) wModel = p0[7:0];
      exec(word);
      checkState();
      check(mem[a], (i < 7) ? x[15:8] : p0[7:0]);
    end
    $display("byte test done");
    for (int i = 0; i < 12; i++) begin
      x = rnd();
      a = 7'h30;
      if (i < 4) begin
        x[7:0] = (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : (i == 2) ? 8'hFF : 8'h07;
        word = {2'b00, (i < 2) ? 4'hB : 4'hF, 1'b1, a};
        sk = (i % 2 == 0);
      end else begin
        word = {2'b01, 1'b1, x[11], x[10:8], a};
        sk = x[11] ? x[x[10:8]] : !x[x[10:8]];
      end
      mem[a] <= x[7:0];
      rd(rid_pkg::OFS_PC, p0);
      exec(word);
      rd(rid_pkg::OFS_PC, p1);
      check(p1[12:0], 13'(p0[12:0] + (sk ? 13'd2 : 13'd1)));
      if (i < 4) check(mem[a], (i < 2) ? 8'(x[7:0] - 8'h01) : 8'(x[7:0] + 8'h01));
      checkState();
    end
    $display("skip test done");
    x = rnd();
    rd(rid_pkg::OFS_PC, p0);
    exec({3'b100, x[10:0]});
    rd(rid_pkg::OFS_PC, p1);
    check(p1[12:0], {2'b00, x[10:0]});
    wModel = x[23:16];
    exec({6'b110100, wModel});
    rd(rid_pkg::OFS_PC, p1);
    check(p1[12:0], 13'(p0[12:0] + 13'd1));
    checkState();
    // A second word while the jump still runs its no-op cycle must be refused
    axiWrite(rid_pkg::OFS_INSTR, {18'h0_0000, 3'b101, x[26:16]}, r);
    axiWrite(rid_pkg::OFS_INSTR, 32'h0000_3055, r);
    check(r, rid_pkg::RESP_ERR);
    waitIdle();
    rd(rid_pkg::OFS_PC, p1);
    check(p1[12:0], {2'b00, x[26:16]});
    axiWrite(rid_pkg::OFS_STATUS, 32'h0000_0000, r);
    check(r, rid_pkg::RESP_ERR);
    axiRead(8'h10, v, r);
    check({v, r}, {32'h0000_0000, rid_pkg::RESP_ERR});
    $display("control test done");
    for (int i = 0; i < 3; i++) begin
      presTo0 <= (i != 1);
      p0 = nPres;
      exec({2'b00, 4'h4, i != 2, rid_pkg::TIMER0_ADDR});
      check(nPres - p0, (i == 0) ? 1 : 0);
    end
    x = rnd();
    pins <= x[7:0];
    mem[rid_pkg::PORT_ADDR] <= ~x[7:0];
    repeat (4) @(posedge clock);
    exec({2'b00, 4'h9, 1'b1, rid_pkg::PORT_ADDR});
    check(lastWr, 8'(~x[7:0]));
    $display("side effect test done");
    p0 = nWdog;
    exec(rid_pkg::W_CLEAR_WATCHDOG);
    check(nWdog - p0, 1);
    exec(rid_pkg::W_SLEEP);
    rd(rid_pkg::OFS_STATUS, v);
    check({standby, v[7], v[4:3]}, 4'b1110);
    exec(14'h0000);
    check(standby, 1'b0);
    $display("power test done");
    end_sim();
  end
endmodule : test_risc14_instruction_decoder
